/* File: dv/ubg_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// Host processor model on the register port
// ---------------------------------------------------------------
// Each access holds its strobe for one taken edge, then releases.
// Released address and data lines show the inverse of the last value,
// so a stale value left on them cannot look like a good one.
module ubg_host_model
  import ubg_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Requests
  output logic [3:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o,
  // Answer
  input wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 4'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // One write; the request stands across exactly one rising edge.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask : wr

  // One read; the answer is registered at the taken edge.
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask : rd

  // Both latches are always written, with the divisor latch access bit set first.
  task automatic set_div(input logic [15:0] div);
    wr(ADDR_LCR, 8'h80);
    wr(ADDR_DATA, div[7:0]);
    wr(ADDR_IER, div[15:8]);
    wr(ADDR_LCR, 8'h03);
  endtask : set_div
endmodule : ubg_host_model

`default_nettype wire

/* File: dv/ubg_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none

// ---------------------------------------------------------------
// Self-checking bench for the baud generator and register select
// ---------------------------------------------------------------
module ubg_top_bench
  import ubg_pkg::*;
;

  typedef struct {logic [3:0] a; logic [7:0] w; logic [7:0] s; logic [7:0] e;} ubg_row_t;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rx_data = 8'h00;
  logic [7:0] interrupt_identification_register = 8'h00;
  logic [7:0] stat = 8'h00;
  logic tx_push, rx_pop, iir_read, fcr_write, soft_rst, tick;
  logic [7:0] tx_data, ier, fifo_control_register, line_control_register, line_control_aux_register, enhanced_feature_register, extra_features_register, flow_threshold_register, trigger_level_register;
  logic [31:0] flow;
  logic [7:0] got;
  logic [31:0] gap;
  int errors = 0;
  int checks_done = 0;
  int ticks;
  ubg_row_t rows[11];

  always #2.5 clk = ~clk;

  ubg_host_model host_u (.clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata), .rdata_i(rdata));

  ubg_top dut_u (
    .CLK_I(clk), .RESET_N_I(rst_n), .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .WDATA_I(wdata),
    .RDATA_O(rdata), .RX_DATA_I(rx_data), .IIR_I(interrupt_identification_register), .LSR_I(stat), .MSR_I(stat),
    .TRANSMIT_FILL_LEVEL_I(stat), .RECEIVE_FILL_LEVEL_I(stat), .TX_PUSH_O(tx_push), .TX_DATA_O(tx_data), .RX_POP_O(rx_pop),
    .IIR_READ_O(iir_read), .FCR_WRITE_O(fcr_write), .IER_O(ier), .FCR_O(fifo_control_register), .LCR_O(line_control_register),
    .MCR_O(line_control_aux_register), .EFR_O(enhanced_feature_register), .EXTRA_FEATURES_REGISTER_O(extra_features_register), .TCR_O(flow_threshold_register), .TLR_O(trigger_level_register), .FLOW_CHARS_O(flow),
    .SOFT_RESET_O(soft_rst), .BAUD16_TICK_O(tick)
  );

  // Single comparison point; unknowns never match.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Cycles from one tick to the next, sampled just after each edge.
  task automatic tick_gap(output logic [31:0] n);
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 1100) begin
      @(posedge clk);
      #1;
      k++;
    end
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 1100);
  endtask : tick_gap

  // Single closing point of the run.
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Watchdog sized well beyond the whole sequence.
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end

  initial begin
    // Write, status value, expected read: plain, gated and read-only places.
    rows = '{'{4'h1, 8'h5a, 8'h00, 8'h5a}, '{4'h3, 8'h1b, 8'h00, 8'h1b}, '{4'h4, 8'h84, 8'h00, 8'h04},
             '{4'h7, 8'hc3, 8'h00, 8'hc3}, '{4'hf, 8'h3c, 8'h00, 8'h3c}, '{4'h5, 8'hff, 8'h60, 8'h60},
             '{4'h6, 8'hff, 8'h11, 8'h11}, '{4'h8, 8'hff, 8'h40, 8'h40}, '{4'h9, 8'hff, 8'h07, 8'h07},
             '{4'ha, 8'hff, 8'h00, 8'h00}, '{4'he, 8'h00, 8'h00, 8'h00}};
    repeat (20) @(posedge clk);
    #1;
    rst_n = 1'b1;
    check("lcr after reset", line_control_register, LCR_RESET);
    check("prescale after reset", line_control_aux_register[PRESC_SEL_BIT], 1'b0);
    check("tick after reset", tick, 1'b0);
    // The latches are unknown until written, and an unknown count never reloads cleanly.
    // A zero divisor parks the counter at a known value before any real setting.
    host_u.set_div(16'h0000);

    // -------------------------------------------------------------
    // Ordinary registers through the table
    // -------------------------------------------------------------
    foreach (rows[i]) begin
      stat = rows[i].s;
      host_u.wr(rows[i].a, rows[i].w);
      host_u.rd(rows[i].a, got);
      check("row readback", got, rows[i].e);
    end
    check("ier out", ier, 8'h5a);
    check("extra_features_register out", extra_features_register, 8'h3c);
    host_u.wr(ADDR_LCR, 8'h03);

    // -------------------------------------------------------------
    // Shared addresses split by direction
    // -------------------------------------------------------------
    host_u.wr(ADDR_DATA, 8'h55);
    check("tx push", {tx_push, tx_data}, {1'b1, 8'h55});
    rx_data = 8'ha6;
    host_u.rd(ADDR_DATA, got);
    check("rx pop", {rx_pop, got}, {1'b1, 8'ha6});
    host_u.wr(ADDR_FIFO, 8'h41);
    check("fifo ctrl", {fcr_write, fifo_control_register}, {1'b1, 8'h41});
    interrupt_identification_register = 8'hc1;
    host_u.rd(ADDR_FIFO, got);
    check("iir read", {iir_read, got}, {1'b1, 8'hc1});

    // -------------------------------------------------------------
    // Divisor latches, access gate and tick spacing
    // -------------------------------------------------------------
    host_u.set_div(16'h0003);
    host_u.wr(ADDR_LCR, 8'h80);
    host_u.rd(ADDR_DATA, got);
    check("divisor low", got, 8'h03);
    check("no pop on latch read", rx_pop, 1'b0);
    host_u.rd(ADDR_IER, got);
    check("divisor high", got, 8'h00);
    host_u.wr(ADDR_LCR, 8'h03);
    host_u.rd(ADDR_DATA, got);
    check("gate closed", got, rx_data);
    tick_gap(gap);
    tick_gap(gap);
    check("gap div 3", gap, 32'd3);
    host_u.set_div(16'h0102);
    tick_gap(gap);
    tick_gap(gap);
    check("gap div 258", gap, 32'd258);
    host_u.set_div(16'h0001);
    tick_gap(gap);
    tick_gap(gap);
    check("gap div 1", gap, 32'd1);
    host_u.set_div(16'h0003);

    // -------------------------------------------------------------
    // Enhanced bank, prescaler and threshold registers
    // -------------------------------------------------------------
    host_u.wr(ADDR_MCR, 8'h80);
    check("prescale locked", line_control_aux_register[PRESC_SEL_BIT], 1'b0);
    host_u.wr(ADDR_LCR, LCR_ENH_KEY);
    host_u.wr(ADDR_FIFO, 8'h10);
    check("enhanced reg", enhanced_feature_register, 8'h10);
    for (int j = 4; j < 8; j++) begin
      host_u.wr(j[3:0], 8'hd0 + j[7:0]);
    end
    host_u.wr(ADDR_LCR, 8'h03);
    check("flow chars", flow, 32'hd7d6d5d4);
    host_u.wr(ADDR_MCR, 8'h84);
    check("prescale set", line_control_aux_register, 8'h84);
    tick_gap(gap);
    tick_gap(gap);
    check("gap div 3 x4", gap, 32'd12);
    host_u.wr(ADDR_MSR, 8'ha5);
    host_u.wr(ADDR_SPR, 8'h5a);
    check("thresholds", {flow_threshold_register, trigger_level_register}, 16'ha55a);
    host_u.rd(ADDR_MSR, got);
    check("threshold read", got, 8'ha5);

    // -------------------------------------------------------------
    // Software reset keeps divisor and flow characters
    // -------------------------------------------------------------
    host_u.wr(ADDR_SRST, 8'h08);
    check("soft reset pulse", soft_rst, 1'b1);
    @(posedge clk);
    #1;
    check("lcr after soft reset", line_control_register, LCR_RESET);
    check("mcr after soft reset", line_control_aux_register, 8'h00);
    check("flow kept", flow, 32'hd7d6d5d4);
    tick_gap(gap);
    tick_gap(gap);
    check("divisor kept", gap, 32'd3);

    // -------------------------------------------------------------
    // Zero divisor stops the tick
    // -------------------------------------------------------------
    host_u.set_div(16'h0000);
    repeat (20) @(posedge clk);
    #1;
    ticks = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      ticks += (tick === 1'b1) ? 1 : 0;
    end
    check("ticks at zero", ticks, 32'd0);
    give_verdict();
  end
endmodule : ubg_top_bench

`default_nettype wire

/* File: hw/ubg_baud_counter.sv */
`timescale 1ns/100ps
`default_nettype none

module ubg_baud_counter
  import ubg_pkg::*;
#(
  parameter int WIDTH = DIV_WIDTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Prescaled enable and divisor
  input wire logic en_i,
  input wire logic [WIDTH-1:0] divisor_i,
  // Oversample tick
  output logic tick_o
);

  // ---------------------------------------------------------------
  // Down counter
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic tick_q;
  logic tick_d;

  // A zero divisor parks the counter so no tick ever leaves it.
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (divisor_i == '0) begin
      cnt_d = '0;
    end else if (en_i) begin
      if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        tick_d = 1'b1;
        cnt_d = divisor_i;
      end else begin
        cnt_d = cnt_q - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule : ubg_baud_counter

`default_nettype wire

/* File: hw/ubg_prescaler.sv */
`timescale 1ns/100ps
`default_nettype none

module ubg_prescaler
  import ubg_pkg::*;
#(
  parameter int RATIO = PRESC_RATIO
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic div4_sel_i,
  // Enable out
  output logic en_o
);

  // ---------------------------------------------------------------
  // Free running phase counter
  // ---------------------------------------------------------------
  logic [$clog2(RATIO)-1:0] cnt_q;
  logic [$clog2(RATIO)-1:0] cnt_d;

  // Wraps naturally, so the divide-by-four phase never needs a compare.
  always_comb begin
    cnt_d = cnt_q + 1'b1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Every cycle when bypassed, once per wrap when dividing.
  assign en_o = div4_sel_i ? (cnt_q == RATIO[$clog2(RATIO)-1:0] - 1'b1) : 1'b1;

endmodule : ubg_prescaler

`default_nettype wire

/* File: hw/ubg_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Divide clock by 16-bit divisor 1..65535.
// - Control bit selects divide-by-1 or divide-by-4 prescale.
// - Generator output is sixteen times baud rate.
// - Reset selects divide-by-1 prescaler.
// - Divisor built from low and high latches.
// - Zero divisor produces no baud tick.
// - One tick drives transmitter and receiver.
// - Prescale bit writable only with enhanced enable.
// - Threshold registers need enhanced and threshold enables.
// - Divisor latches need divisor latch access bit.
// - Enhanced registers need line control 0xbf.
// - Data address: read receive, write transmit.
// - Shared address: read identification, write FIFO control.
// - Status and level registers ignore host writes.
// - Divisor, scratch, flow characters survive all resets.
module ubg_top
  import ubg_pkg::*;
#(
  parameter int WIDTH = DIV_WIDTH
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // Host register port
  input wire logic [3:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  output logic [7:0] RDATA_O,
  // Status supplied by the rest of the UART
  input wire logic [7:0] RX_DATA_I,
  input wire logic [7:0] IIR_I,
  input wire logic [7:0] LSR_I,
  input wire logic [7:0] MSR_I,
  input wire logic [7:0] TRANSMIT_FILL_LEVEL_I,
  input wire logic [7:0] RECEIVE_FILL_LEVEL_I,
  // Data and access strobes to the rest of the UART
  output logic TX_PUSH_O,
  output logic [7:0] TX_DATA_O,
  output logic RX_POP_O,
  output logic IIR_READ_O,
  output logic FCR_WRITE_O,
  // Configuration to the rest of the UART
  output logic [7:0] IER_O,
  output logic [7:0] FCR_O,
  output logic [7:0] LCR_O,
  output logic [7:0] MCR_O,
  output logic [7:0] EFR_O,
  output logic [7:0] EXTRA_FEATURES_REGISTER_O,
  output logic [7:0] TCR_O,
  output logic [7:0] TLR_O,
  output logic [31:0] FLOW_CHARS_O,
  output logic SOFT_RESET_O,
  // Shared sixteen times baud tick
  output logic BAUD16_TICK_O
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  logic [7:0] lcr_q, mcr_q, efr_q, ier_q, fcr_q, extra_features_register_q, tcr_q, tlr_q;
  logic srst_q;
  logic rst_int;
  ubg_sel_t sel;

  assign rst_int = !RESET_N_I || srst_q;

  // The general map is decoded first; the banked windows then override it, with the 0xbf bank applied last so it wins.
  always_comb begin
    sel = SEL_NONE;
    case (ADDR_I)
      ADDR_DATA: sel = SEL_DATA;
      ADDR_IER: sel = SEL_IER;
      ADDR_FIFO: sel = SEL_FIFO;
      ADDR_LCR: sel = SEL_LCR;
      ADDR_MCR: sel = SEL_MCR;
      ADDR_LSR: sel = SEL_LSR;
      ADDR_MSR: sel = SEL_MSR;
      ADDR_SPR: sel = SEL_SPR;
      ADDR_TRANSMIT_FILL_LEVEL: sel = SEL_TRANSMIT_FILL_LEVEL;
      ADDR_RECEIVE_FILL_LEVEL: sel = SEL_RECEIVE_FILL_LEVEL;
      ADDR_SRST: sel = SEL_SRST;
      ADDR_EXTRA_FEATURES_REGISTER: sel = SEL_EXTRA_FEATURES_REGISTER;
      default: sel = SEL_NONE;
    endcase
    if (efr_q[ENH_EN_BIT] && mcr_q[THRESH_EN_BIT]) begin
      if (ADDR_I == ADDR_MSR) sel = SEL_TCR;
      if (ADDR_I == ADDR_SPR) sel = SEL_TLR;
    end
    if (lcr_q[DIV_ACCESS_BIT]) begin
      if (ADDR_I == ADDR_DATA) sel = SEL_DLL;
      if (ADDR_I == ADDR_IER) sel = SEL_DLH;
    end
    if (lcr_q == LCR_ENH_KEY) begin
      case (ADDR_I)
        ADDR_FIFO: sel = SEL_EFR;
        ADDR_MCR: sel = SEL_RESUME_CHAR_ONE;
        ADDR_LSR: sel = SEL_RESUME_CHAR_TWO;
        ADDR_MSR: sel = SEL_PAUSE_CHAR_ONE;
        ADDR_SPR: sel = SEL_PAUSE_CHAR_TWO;
        default: sel = sel;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Resettable control registers
  // ---------------------------------------------------------------
  logic [7:0] lcr_d, mcr_d, efr_d, ier_d, fcr_d, extra_features_register_d, tcr_d, tlr_d;
  logic srst_d;

  // Status and level addresses have no write case, so writes there vanish.
  always_comb begin
    lcr_d = lcr_q;
    mcr_d = mcr_q;
    efr_d = efr_q;
    ier_d = ier_q;
    fcr_d = fcr_q;
    extra_features_register_d = extra_features_register_q;
    tcr_d = tcr_q;
    tlr_d = tlr_q;
    if (WR_I) begin
      case (sel)
        SEL_LCR: lcr_d = WDATA_I;
        SEL_MCR: begin
          mcr_d = WDATA_I;
          if (!efr_q[ENH_EN_BIT]) begin
            mcr_d[PRESC_SEL_BIT] = mcr_q[PRESC_SEL_BIT];
          end
        end
        SEL_EFR: efr_d = WDATA_I;
        SEL_IER: ier_d = WDATA_I;
        SEL_FIFO: fcr_d = WDATA_I;
        SEL_EXTRA_FEATURES_REGISTER: extra_features_register_d = WDATA_I;
        SEL_TCR: tcr_d = WDATA_I;
        SEL_TLR: tlr_d = WDATA_I;
        default: lcr_d = lcr_q;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (rst_int) begin
      lcr_q <= LCR_RESET;
      mcr_q <= CTRL_RESET;
      efr_q <= CTRL_RESET;
      ier_q <= CTRL_RESET;
      fcr_q <= CTRL_RESET;
      extra_features_register_q <= CTRL_RESET;
      tcr_q <= CTRL_RESET;
      tlr_q <= CTRL_RESET;
    end else begin
      lcr_q <= lcr_d;
      mcr_q <= mcr_d;
      efr_q <= efr_d;
      ier_q <= ier_d;
      fcr_q <= fcr_d;
      extra_features_register_q <= extra_features_register_d;
      tcr_q <= tcr_d;
      tlr_q <= tlr_d;
    end
  end

  // Software reset is a one-cycle pulse; only the pin clears it, so it cannot lock itself.
  always_comb begin
    srst_d = WR_I && (sel == SEL_SRST) && WDATA_I[SRST_BIT];
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= srst_d;
    end
  end

  // ---------------------------------------------------------------
  // Retained storage
  // ---------------------------------------------------------------
  // No reset at all here: the baud setting and flow characters survive any reset.
  // Until software writes them they are unknown in simulation.
  logic [7:0] keep_q [0:6];
  logic [7:0] keep_d [0:6];
  ubg_sel_t keep_sel [0:6];

  assign keep_sel[0] = SEL_DLL;
  assign keep_sel[1] = SEL_DLH;
  assign keep_sel[2] = SEL_SPR;
  assign keep_sel[3] = SEL_RESUME_CHAR_ONE;
  assign keep_sel[4] = SEL_RESUME_CHAR_TWO;
  assign keep_sel[5] = SEL_PAUSE_CHAR_ONE;
  assign keep_sel[6] = SEL_PAUSE_CHAR_TWO;

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_keep
      // Each entry loads only when its own address window is open.
      always_comb begin
        keep_d[gi] = (WR_I && sel == keep_sel[gi]) ? WDATA_I : keep_q[gi];
      end

      always_ff @(posedge CLK_I) begin
        keep_q[gi] <= keep_d[gi];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data and access strobes
  // ---------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d, txd_q, txd_d;
  logic push_q, push_d, pop_q, pop_d, iir_q, iir_d, fcrw_q, fcrw_d;

  // Side effects follow the decoded target, so a gated read never touches a banked register.
  always_comb begin
    rdata_d = rdata_q;
    txd_d = txd_q;
    push_d = WR_I && (sel == SEL_DATA);
    fcrw_d = WR_I && (sel == SEL_FIFO);
    pop_d = RD_I && (sel == SEL_DATA);
    iir_d = RD_I && (sel == SEL_FIFO);
    if (push_d) txd_d = WDATA_I;
    if (RD_I) begin
      case (sel)
        SEL_DATA: rdata_d = RX_DATA_I;
        SEL_IER: rdata_d = ier_q;
        SEL_FIFO: rdata_d = IIR_I;
        SEL_LCR: rdata_d = lcr_q;
        SEL_MCR: rdata_d = mcr_q;
        SEL_LSR: rdata_d = LSR_I;
        SEL_MSR: rdata_d = MSR_I;
        SEL_SPR: rdata_d = keep_q[2];
        SEL_TCR: rdata_d = tcr_q;
        SEL_TLR: rdata_d = tlr_q;
        SEL_TRANSMIT_FILL_LEVEL: rdata_d = TRANSMIT_FILL_LEVEL_I;
        SEL_RECEIVE_FILL_LEVEL: rdata_d = RECEIVE_FILL_LEVEL_I;
        SEL_SRST: rdata_d = 8'h00;
        SEL_EXTRA_FEATURES_REGISTER: rdata_d = extra_features_register_q;
        SEL_DLL: rdata_d = keep_q[0];
        SEL_DLH: rdata_d = keep_q[1];
        SEL_EFR: rdata_d = efr_q;
        SEL_RESUME_CHAR_ONE: rdata_d = keep_q[3];
        SEL_RESUME_CHAR_TWO: rdata_d = keep_q[4];
        SEL_PAUSE_CHAR_ONE: rdata_d = keep_q[5];
        SEL_PAUSE_CHAR_TWO: rdata_d = keep_q[6];
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESET_N_I) begin
      rdata_q <= 8'h00;
      txd_q <= 8'h00;
      push_q <= 1'b0;
      pop_q <= 1'b0;
      iir_q <= 1'b0;
      fcrw_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      txd_q <= txd_d;
      push_q <= push_d;
      pop_q <= pop_d;
      iir_q <= iir_d;
      fcrw_q <= fcrw_d;
    end
  end

  // ---------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------
  logic presc_en;
  logic [WIDTH-1:0] divisor;
  logic baud_tick;

  assign divisor = {keep_q[1], keep_q[0]};

  ubg_prescaler #(.RATIO(PRESC_RATIO)) u_presc (
    .clk_i(CLK_I),
    .rst_i(rst_int),
    .div4_sel_i(mcr_q[PRESC_SEL_BIT]),
    .en_o(presc_en)
  );

  // Tick rate is clock / prescale / divisor, i.e. OVERSAMPLE times the baud rate.
  ubg_baud_counter #(.WIDTH(WIDTH)) u_baud (
    .clk_i(CLK_I),
    .rst_i(rst_int),
    .en_i(presc_en),
    .divisor_i(divisor),
    .tick_o(baud_tick)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign BAUD16_TICK_O = baud_tick;
  assign RDATA_O = rdata_q;
  assign TX_PUSH_O = push_q;
  assign TX_DATA_O = txd_q;
  assign RX_POP_O = pop_q;
  assign IIR_READ_O = iir_q;
  assign FCR_WRITE_O = fcrw_q;
  assign IER_O = ier_q;
  assign FCR_O = fcr_q;
  assign LCR_O = lcr_q;
  assign MCR_O = mcr_q;
  assign EFR_O = efr_q;
  assign EXTRA_FEATURES_REGISTER_O = extra_features_register_q;
  assign TCR_O = tcr_q;
  assign TLR_O = tlr_q;
  assign FLOW_CHARS_O = {keep_q[6], keep_q[5], keep_q[4], keep_q[3]};
  assign SOFT_RESET_O = srst_q;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_presc_reset;
    @(posedge CLK_I) !RESET_N_I |=> !mcr_q[PRESC_SEL_BIT] && !presc_en == 1'b0;
  endproperty
  a_presc_reset: assert property (p_presc_reset) else $error("prescaler not divide-by-1 after reset");

  property p_presc_gate;
    @(posedge CLK_I) disable iff (rst_int)
    WR_I && sel == SEL_MCR && !efr_q[ENH_EN_BIT] |=> mcr_q[PRESC_SEL_BIT] == $past(mcr_q[PRESC_SEL_BIT]);
  endproperty
  a_presc_gate: assert property (p_presc_gate) else $error("prescale bit changed without enable");

  property p_div4_spacing;
    @(posedge CLK_I) disable iff (rst_int)
    (presc_en && mcr_q[PRESC_SEL_BIT]) ##1 mcr_q[PRESC_SEL_BIT] [*3] |-> $past(!presc_en) && presc_en == 1'b0 ##1 presc_en;
  endproperty
  a_div4_spacing: assert property (p_div4_spacing) else $error("divide-by-4 enable spacing wrong");

  property p_zero_div;
    @(posedge CLK_I) disable iff (rst_int)
    $past(divisor) == '0 |-> !BAUD16_TICK_O;
  endproperty
  a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

  property p_period_three;
    @(posedge CLK_I) disable iff (rst_int)
    (BAUD16_TICK_O && $past(divisor) == 16'h0003 && divisor == 16'h0003 && !mcr_q[PRESC_SEL_BIT])
    ##1 (divisor == 16'h0003 && !mcr_q[PRESC_SEL_BIT]) [*2] |-> !BAUD16_TICK_O ##1 BAUD16_TICK_O;
  endproperty
  a_period_three: assert property (p_period_three) else $error("divisor 3 period wrong");

  property p_dll_write;
    @(posedge CLK_I) WR_I && lcr_q[DIV_ACCESS_BIT] && ADDR_I == ADDR_DATA |=> keep_q[0] == $past(WDATA_I);
  endproperty
  a_dll_write: assert property (p_dll_write) else $error("low divisor latch not loaded");

  property p_keep_soft_reset;
    @(posedge CLK_I) srst_q && !WR_I |=> divisor == $past(divisor);
  endproperty
  a_keep_soft_reset: assert property (p_keep_soft_reset) else $error("divisor lost on soft reset");

  property p_efr_key;
    @(posedge CLK_I) disable iff (rst_int)
    WR_I && ADDR_I == ADDR_FIFO |=> (efr_q == $past(WDATA_I)) == ($past(lcr_q) == LCR_ENH_KEY) || $past(efr_q) == $past(WDATA_I);
  endproperty
  a_efr_key: assert property (p_efr_key) else $error("enhanced register access gate wrong");

  property p_tcr_gate;
    @(posedge CLK_I) disable iff (rst_int)
    WR_I && ADDR_I == ADDR_MSR && !(efr_q[ENH_EN_BIT] && mcr_q[THRESH_EN_BIT]) |=> $stable(tcr_q);
  endproperty
  a_tcr_gate: assert property (p_tcr_gate) else $error("threshold register written while locked");

  property p_thr_push;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    WR_I && ADDR_I == ADDR_DATA && !lcr_q[DIV_ACCESS_BIT] |=> TX_PUSH_O && TX_DATA_O == $past(WDATA_I) && !RX_POP_O;
  endproperty
  a_thr_push: assert property (p_thr_push) else $error("transmit write not pushed");

  property p_iir_read;
    @(posedge CLK_I) disable iff (!RESET_N_I)
    RD_I && ADDR_I == ADDR_FIFO && lcr_q != LCR_ENH_KEY |=> IIR_READ_O && RDATA_O == $past(IIR_I);
  endproperty
  a_iir_read: assert property (p_iir_read) else $error("identification read wrong");

  property p_status_ro;
    @(posedge CLK_I) disable iff (rst_int)
    WR_I && ADDR_I == ADDR_TRANSMIT_FILL_LEVEL |=> $stable(lcr_q) && $stable(mcr_q) && $stable(ier_q) && !TX_PUSH_O;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("write to read-only register had effect");

endmodule : ubg_top

`default_nettype wire

/* File: shared/ubg_pkg.sv */
package ubg_pkg;

  // ---------------------------------------------------------------
  // Register addresses on the host port
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_IER = 4'h1;
  localparam logic [3:0] ADDR_FIFO = 4'h2;
  localparam logic [3:0] ADDR_LCR = 4'h3;
  localparam logic [3:0] ADDR_MCR = 4'h4;
  localparam logic [3:0] ADDR_LSR = 4'h5;
  localparam logic [3:0] ADDR_MSR = 4'h6;
  localparam logic [3:0] ADDR_SPR = 4'h7;
  localparam logic [3:0] ADDR_TRANSMIT_FILL_LEVEL = 4'h8;
  localparam logic [3:0] ADDR_RECEIVE_FILL_LEVEL = 4'h9;
  localparam logic [3:0] ADDR_SRST = 4'he;
  localparam logic [3:0] ADDR_EXTRA_FEATURES_REGISTER = 4'hf;

  // ---------------------------------------------------------------
  // Field positions and special values
  // ---------------------------------------------------------------
  localparam int PRESC_SEL_BIT = 7;
  localparam int THRESH_EN_BIT = 2;
  localparam int ENH_EN_BIT = 4;
  localparam int DIV_ACCESS_BIT = 7;
  localparam int SRST_BIT = 3;
  localparam logic [7:0] LCR_ENH_KEY = 8'hbf;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [7:0] LCR_RESET = 8'h1d;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ---------------------------------------------------------------
  // Generator constants
  // ---------------------------------------------------------------
  localparam int DIV_WIDTH = 16;
  localparam int PRESC_RATIO = 4;
  localparam int OVERSAMPLE = 16;

  // Register selected by one host access.
  typedef enum logic [4:0] {
    SEL_NONE = 5'b00000,
    SEL_DATA = 5'b00001,
    SEL_IER = 5'b00010,
    SEL_FIFO = 5'b00011,
    SEL_LCR = 5'b00100,
    SEL_MCR = 5'b00101,
    SEL_LSR = 5'b00110,
    SEL_MSR = 5'b00111,
    SEL_SPR = 5'b01000,
    SEL_TCR = 5'b01001,
    SEL_TLR = 5'b01010,
    SEL_TRANSMIT_FILL_LEVEL = 5'b01011,
    SEL_RECEIVE_FILL_LEVEL = 5'b01100,
    SEL_SRST = 5'b01101,
    SEL_EXTRA_FEATURES_REGISTER = 5'b01110,
    SEL_DLL = 5'b01111,
    SEL_DLH = 5'b10000,
    SEL_EFR = 5'b10001,
    SEL_RESUME_CHAR_ONE = 5'b10010,
    SEL_RESUME_CHAR_TWO = 5'b10011,
    SEL_PAUSE_CHAR_ONE = 5'b10100,
    SEL_PAUSE_CHAR_TWO = 5'b10101
  } ubg_sel_t;

endpackage : ubg_pkg
